// *** logic/art_defines.svh ***
// Offsets, field positions, reset values and divider counts of the reload timer.
// Assumes an 8-bit special-function-register space with bit addressing.
`ifndef ART_DEFINES_SVH
`define ART_DEFINES_SVH

// Register addresses
`define ART_CTRL_ADDR 8'hC8
`define ART_RELOAD_LOW_ADDR 8'hCA
`define ART_RELOAD_HIGH_ADDR 8'hCB
`define ART_COUNT_LOW_ADDR 8'hCC
`define ART_COUNT_HIGH_ADDR 8'hCD

// Control field positions
`define ART_HIGH_FLAG_BIT 7
`define ART_LOW_FLAG_BIT 6
`define ART_LOW_IRQ_EN_BIT 5
`define ART_UNUSED4_BIT 4
`define ART_SPLIT_BIT 3
`define ART_RUN_BIT 2
`define ART_UNUSED1_BIT 1
`define ART_EXT_SEL_BIT 0

// Reset values
`define ART_CTRL_RESET 8'h00
`define ART_BYTE_RESET 8'h00

// Byte wrap point
`define ART_BYTE_MAX 8'hFF

// Divider counts
`define ART_SYS_DIV 12
`define ART_EXT_DIV 8

`endif

// *** logic/art_pkg.sv ***
// Types shared by the reload timer and its tick source.
// Assumes art_defines.svh is on the include path.
`include "art_defines.svh"

package art_pkg;

  // Register state of the timer
  typedef struct packed {
    logic highFlag;
    logic lowFlag;
    logic lowIrqEnable;
    logic splitMode;
    logic runControl;
    logic extClockSel;
    logic [7:0] reloadLow;
    logic [7:0] reloadHigh;
    logic [7:0] countLow;
    logic [7:0] countHigh;
    logic [7:0] rdData;
    logic irq;
  } timer_state_t;

  // Prescaler and external edge state
  typedef struct packed {
    logic [3:0] sysDivCnt;
    logic sysTick;
    logic [2:0] extSync;
    logic extLevel;
    logic [2:0] extDivCnt;
    logic extTick;
  } tick_state_t;

endpackage : art_pkg

// *** logic/tick_if.sv ***
// Tick strobes passed from the tick source to the counter logic.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
`default_nettype none

interface tick_if;
  logic sysDiv12Tick;
  logic extDiv8Tick;
  modport src (output sysDiv12Tick, output extDiv8Tick);
  modport dst (input sysDiv12Tick, input extDiv8Tick);
endinterface : tick_if

`default_nettype wire

// *** logic/tick_source.sv ***
// Makes one-cycle ticks at system_clock/12 and at external clock/8.
// Assumes extClk is asynchronous to sys_clk and no faster than a quarter of its rate.
`timescale 1ns/1ps
`default_nettype none

module tick_source
  import art_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic extClk,
  tick_if.src ticks
);

  tick_state_t s_q;
  tick_state_t s_d;
  logic extRise;

  // Level counts only once stages two and three agree; stage one feeds stage two alone
  always_comb begin
    s_d = s_q;
    extRise = 1'b0;
    s_d.extSync = {s_q.extSync[1:0], extClk};
    if (s_q.extSync[1] == s_q.extSync[2]) begin
      s_d.extLevel = s_q.extSync[2];
      extRise = s_q.extSync[2] & ~s_q.extLevel;
    end
    // Divide synchronized rising edges by eight
    s_d.extTick = 1'b0;
    if (extRise) begin
      s_d.extDivCnt = s_q.extDivCnt + 3'h1;
      s_d.extTick = (s_q.extDivCnt == 3'(`ART_EXT_DIV - 1));
    end
    // Free-running divide by twelve
    s_d.sysTick = (s_q.sysDivCnt == 4'(`ART_SYS_DIV - 1));
    s_d.sysDivCnt = s_d.sysTick ? 4'h0 : s_q.sysDivCnt + 4'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ticks.sysDiv12Tick = s_q.sysTick;
  assign ticks.extDiv8Tick = s_q.extTick;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_sys_div_spacing: assert property (s_q.sysTick |=> !s_q.sysTick [*8] ##0 1)
    else $error("divide-by-twelve tick repeated too soon");
  a_ext_tick_sync: assert property (s_q.extTick |-> $rose(s_q.extLevel))
    else $error("external tick not preceded by a synchronized high level");

endmodule : tick_source

`default_nettype wire

// *** logic/reload_timer.sv ***
// 16-bit auto-reload timer with a split mode of two 8-bit reload timers.
// Assumes a single sys_clk and a processor special-function-register port.
// Notes on behaviour
// - Split select clear: both bytes form one 16-bit up-counter with reload.
// - 16-bit wrap from all ones loads the reload pair and sets high flag.
// - 16-bit mode: each full overflow requests an interrupt when enabled.
// - 16-bit mode: low-byte wrap also interrupts when low interrupt enable set.
// - Split select set: two 8-bit timers, each reloading from its own byte.
// - Split mode: run bit gates only the high byte; low always counts.
// - Per byte: fast select gives system_clock, else /12 or external /8.
// - External divided clock is synchronized to the system clock first.
// - Split mode: high wrap sets high flag, low wrap sets low flag.
// - Split mode: high overflow interrupts; with low enable, either byte does.
// - Hardware never clears the overflow flags; only software writes do.
// - Low flag set on every low-byte wrap in both modes.
// - Control register at 0xC8, bit addressable, fields as laid out, reset zero.
// - Control bit 4 reads zero, ignores writes; bit 1 read only.
// - 16-bit mode counts only while run bit is set.
`timescale 1ns/1ps
`default_nettype none

module reload_timer
  import art_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic bitWr,
  input wire logic [7:0] bitAddr,
  input wire logic bitVal,
  output logic [7:0] sfrRdData,
  input wire logic highFastClockSel,
  input wire logic lowFastClockSel,
  input wire logic extClk,
  input wire logic timerIrqEnable,
  output logic timerIrq
);

  tick_if ticks ();

  tick_source u_ticks (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .extClk(extClk),
    .ticks(ticks.src)
  );

  timer_state_t s_q;
  timer_state_t s_d;
  logic lowTick;
  logic highTick;
  logic lowWrap;
  logic highWrap;
  logic [7:0] ctrlView;
  logic [7:0] ctrlWrite;
  logic ctrlWr;
  logic [15:0] count16;

  // Clock choice per byte; 16-bit mode runs on the low byte's choice
  always_comb begin
    lowTick = lowFastClockSel ? 1'b1 :
      (s_q.extClockSel ? ticks.extDiv8Tick : ticks.sysDiv12Tick);
    highTick = highFastClockSel ? 1'b1 :
      (s_q.extClockSel ? ticks.extDiv8Tick : ticks.sysDiv12Tick);
  end

  // Control image; unused bits 4 and 1 always read zero
  always_comb begin
    ctrlView = 8'h00;
    ctrlView[`ART_HIGH_FLAG_BIT] = s_q.highFlag;
    ctrlView[`ART_LOW_FLAG_BIT] = s_q.lowFlag;
    ctrlView[`ART_LOW_IRQ_EN_BIT] = s_q.lowIrqEnable;
    ctrlView[`ART_SPLIT_BIT] = s_q.splitMode;
    ctrlView[`ART_RUN_BIT] = s_q.runControl;
    ctrlView[`ART_EXT_SEL_BIT] = s_q.extClockSel;
  end

  // Byte and bit writes merge into one control write
  always_comb begin
    ctrlWrite = ctrlView;
    ctrlWr = 1'b0;
    if (sfrWr && sfrAddr == `ART_CTRL_ADDR) begin
      ctrlWrite = sfrWrData;
      ctrlWr = 1'b1;
    end else if (bitWr && bitAddr[7:3] == 5'(`ART_CTRL_ADDR >> 3)) begin
      ctrlWrite[bitAddr[2:0]] = bitVal;
      ctrlWr = 1'b1;
    end
  end

  // Counting, reload, flags, register writes and read data
  always_comb begin
    s_d = s_q;
    lowWrap = 1'b0;
    highWrap = 1'b0;
    count16 = {s_q.countHigh, s_q.countLow};
    if (ctrlWr) begin
      // Bits 4 and 1 have no storage, so writes there vanish
      s_d.highFlag = ctrlWrite[`ART_HIGH_FLAG_BIT];
      s_d.lowFlag = ctrlWrite[`ART_LOW_FLAG_BIT];
      s_d.lowIrqEnable = ctrlWrite[`ART_LOW_IRQ_EN_BIT];
      s_d.splitMode = ctrlWrite[`ART_SPLIT_BIT];
      s_d.runControl = ctrlWrite[`ART_RUN_BIT];
      s_d.extClockSel = ctrlWrite[`ART_EXT_SEL_BIT];
    end
    if (!s_q.splitMode) begin
      if (s_q.runControl && lowTick) begin
        lowWrap = (s_q.countLow == `ART_BYTE_MAX);
        highWrap = (count16 == 16'hFFFF);
        if (highWrap) begin
          {s_d.countHigh, s_d.countLow} = {s_q.reloadHigh, s_q.reloadLow};
        end else begin
          {s_d.countHigh, s_d.countLow} = count16 + 16'h0001;
        end
      end
    end else begin
      if (lowTick) begin
        lowWrap = (s_q.countLow == `ART_BYTE_MAX);
        s_d.countLow = lowWrap ? s_q.reloadLow : s_q.countLow + 8'h01;
      end
      if (s_q.runControl && highTick) begin
        highWrap = (s_q.countHigh == `ART_BYTE_MAX);
        s_d.countHigh = highWrap ? s_q.reloadHigh : s_q.countHigh + 8'h01;
      end
    end
    // Software writes to counts win over counting
    if (sfrWr && sfrAddr == `ART_COUNT_LOW_ADDR) s_d.countLow = sfrWrData;
    if (sfrWr && sfrAddr == `ART_COUNT_HIGH_ADDR) s_d.countHigh = sfrWrData;
    if (sfrWr && sfrAddr == `ART_RELOAD_LOW_ADDR) s_d.reloadLow = sfrWrData;
    if (sfrWr && sfrAddr == `ART_RELOAD_HIGH_ADDR) s_d.reloadHigh = sfrWrData;
    // Hardware set wins over a same-cycle software clear, so no event is lost
    if (highWrap) s_d.highFlag = 1'b1;
    if (lowWrap) s_d.lowFlag = 1'b1;
    // Same gating in both modes: low flag only counts with low enable
    s_d.irq = timerIrqEnable & (s_d.highFlag | (s_d.lowIrqEnable & s_d.lowFlag));
    // Read data captured on a read strobe; unmapped reads give zero
    if (sfrRd) begin
      unique case (sfrAddr)
        `ART_CTRL_ADDR: s_d.rdData = ctrlView;
        `ART_RELOAD_LOW_ADDR: s_d.rdData = s_q.reloadLow;
        `ART_RELOAD_HIGH_ADDR: s_d.rdData = s_q.reloadHigh;
        `ART_COUNT_LOW_ADDR: s_d.rdData = s_q.countLow;
        `ART_COUNT_HIGH_ADDR: s_d.rdData = s_q.countHigh;
        default: s_d.rdData = 8'h00;
      endcase
    end
  end

  // All timer state in one register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfrRdData = s_q.rdData;
  assign timerIrq = s_q.irq;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_wrap16_reload: assert property (!s_q.splitMode && s_q.runControl && lowTick && !sfrWr
      && {s_q.countHigh, s_q.countLow} == 16'hFFFF
      |=> {s_q.countHigh, s_q.countLow} == $past({s_q.reloadHigh, s_q.reloadLow})
      && s_q.highFlag)
    else $error("16-bit wrap did not reload and set high flag");
  a_run_halts: assert property (!s_q.splitMode && !s_q.runControl && !sfrWr
      |=> $stable({s_q.countHigh, s_q.countLow}))
    else $error("16-bit counter moved while stopped");
  a_split_low_free: assert property (s_q.splitMode && !s_q.runControl && lowTick && !sfrWr
      && s_q.countLow != `ART_BYTE_MAX
      |=> s_q.countLow == $past(s_q.countLow) + 8'h01 && $stable(s_q.countHigh))
    else $error("split low byte did not count with run clear");
  a_split_low_reload: assert property (s_q.splitMode && lowTick && !sfrWr
      && s_q.countLow == `ART_BYTE_MAX
      |=> s_q.countLow == $past(s_q.reloadLow) && s_q.lowFlag)
    else $error("split low byte wrap did not reload from its reload byte");
  a_split_high_flag: assert property (s_q.splitMode && s_q.runControl && highTick && !sfrWr
      && s_q.countHigh == `ART_BYTE_MAX
      |=> s_q.countHigh == $past(s_q.reloadHigh) && s_q.highFlag)
    else $error("split high byte wrap did not reload and flag");
  a_flags_sticky: assert property (s_q.highFlag && !ctrlWr |=> s_q.highFlag)
    else $error("high flag cleared without a software write");
  a_low_flag_sticky: assert property (s_q.lowFlag && !ctrlWr |=> s_q.lowFlag)
    else $error("low flag cleared without a software write");
  // Equality binds tighter than the bitwise and, so the gating term is bracketed
  a_irq_gating: assert property (timerIrq == ($past(timerIrqEnable)
      & (s_q.highFlag | (s_q.lowIrqEnable & s_q.lowFlag))))
    else $error("interrupt request does not follow gated flags");
  a_unused_zero: assert property (sfrRd && sfrAddr == `ART_CTRL_ADDR
      |=> sfrRdData[`ART_UNUSED4_BIT] == 1'b0 && sfrRdData[`ART_UNUSED1_BIT] == 1'b0)
    else $error("unused control bits read nonzero");
  a_write_wins: assert property (sfrWr && sfrAddr == `ART_COUNT_LOW_ADDR
      |=> s_q.countLow == $past(sfrWrData))
    else $error("count write lost to counting");

  // Split high byte obeys the run bit; overflows must reach the request line
  a_split_high_hold: assert property (s_q.splitMode && !s_q.runControl && !sfrWr
      |=> $stable(s_q.countHigh))
    else $error("split high byte moved with run clear");
  a_split_high_count: assert property (s_q.splitMode && s_q.runControl && highTick
      && !sfrWr && s_q.countHigh != `ART_BYTE_MAX
      |=> s_q.countHigh == $past(s_q.countHigh) + 8'h01)
    else $error("split high byte did not count while running");
  a_low_wrap16_flag: assert property (!s_q.splitMode && s_q.runControl && lowTick
      && !sfrWr && s_q.countLow == `ART_BYTE_MAX |=> s_q.lowFlag)
    else $error("16-bit low byte wrap did not set low flag");
  a_low_irq16: assert property (!s_q.splitMode && s_q.runControl && lowTick
      && !sfrWr && !ctrlWr && timerIrqEnable && s_q.lowIrqEnable
      && s_q.countLow == `ART_BYTE_MAX |=> timerIrq)
    else $error("16-bit low byte wrap did not request an interrupt");
  a_high_irq: assert property (timerIrqEnable && s_q.highFlag && !ctrlWr |=> timerIrq)
    else $error("high flag with enable did not request an interrupt");

endmodule : reload_timer

`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the reload timer: register access, both modes, clock sources.
// Assumes the timer's defines header is on the include path and sys_clk runs at 10 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "art_defines.svh"

module tb;
  localparam logic [7:0] CTRL = `ART_CTRL_ADDR;
  localparam logic [7:0] CNTL = `ART_COUNT_LOW_ADDR;
  localparam logic [7:0] CNTH = `ART_COUNT_HIGH_ADDR;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrWr = 1'b0;
  logic sfrRd = 1'b0;
  logic bitWr = 1'b0;
  logic [7:0] bitAddr = 8'h00;
  logic bitVal = 1'b0;
  logic [7:0] sfrRdData;
  logic highFast = 1'b0;
  logic lowFast = 1'b0;
  logic extClk = 1'b0;
  logic irqEn = 1'b0;
  logic timerIrq;
  logic [7:0] rdVal;
  logic [7:0] rl;
  logic [7:0] rh;
  int miscompares = 0;
  int checks = 0;
  int seed = 80;

  reload_timer i_reload_timer (.sys_clk(sys_clk), .reset_n(reset_n), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd), .bitWr(bitWr), .bitAddr(bitAddr),
    .bitVal(bitVal), .sfrRdData(sfrRdData), .highFastClockSel(highFast),
    .lowFastClockSel(lowFast), .extClk(extClk), .timerIrqEnable(irqEn), .timerIrq(timerIrq));

  // Free-running system clock
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  // Window check; counts read on the fly drift by a few ticks
  function automatic logic [7:0] inRange(input logic [7:0] v, input int lo, input int hi);
    return {7'h0, (v >= lo) && (v <= hi)};
  endfunction : inRange

  // All drivers move one ns after the edge and leave an idle edge behind
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a;
    sfrWrData = d;
    sfrWr = 1'b1;
    tick(1);
    sfrWr = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfrAddr = a;
    sfrRd = 1'b1;
    tick(1);
    sfrRd = 1'b0;
    tick(1);
    d = sfrRdData;
  endtask : rd

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp, msg);
  endtask : rdChk

  task automatic bw(input logic [7:0] a, input logic v);
    bitAddr = a;
    bitVal = v;
    bitWr = 1'b1;
    tick(1);
    bitWr = 1'b0;
    tick(1);
  endtask : bw

  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #(100 * 3000);
    miscompares++;
    end_of_test();
  end

  initial begin
    rl = 8'($random(seed)) & 8'h7F;
    rh = 8'($random(seed));
    tick(20);
    reset_n = 1'b1;
    rdChk(CTRL, 8'h00, "control reset");
    rdChk(8'h00, 8'h00, "unmapped read");
    wr(CTRL, 8'h12);
    rdChk(CTRL, 8'h00, "unused byte write");
    bw(8'hCC, 1'b1);
    rdChk(CTRL, 8'h00, "unused bit write");
    wr(`ART_RELOAD_LOW_ADDR, rl);
    wr(`ART_RELOAD_HIGH_ADDR, rh);
    rdChk(`ART_RELOAD_LOW_ADDR, rl, "reload low");
    rdChk(`ART_RELOAD_HIGH_ADDR, rh, "reload high");
    // 16-bit wrap from all ones on the fast clock
    lowFast = 1'b1;
    irqEn = 1'b1;
    wr(CNTL, 8'hFE);
    wr(CNTH, 8'hFF);
    tick(20);
    rdChk(CNTL, 8'hFE, "held while stopped");
    wr(CTRL, 8'h04);
    tick(8);
    bw(8'hCA, 1'b0);
    chk({7'h0, timerIrq}, 8'h01, "full overflow irq");
    rd(CTRL, rdVal);
    chk(rdVal & 8'h80, 8'h80, "high flag on wrap");
    rdChk(CNTH, rh, "high reloaded");
    rd(CNTL, rdVal);
    chk(inRange(8'(rdVal - rl), 3, 14), 8'h01, "low counts from reload");
    wr(CTRL, 8'h00);
    chk({7'h0, timerIrq}, 8'h00, "irq drops with flags");
    // Low-byte wrap only, low interrupt enabled
    wr(CNTL, 8'hFE);
    wr(CNTH, 8'h00);
    wr(CTRL, 8'h24);
    tick(6);
    bw(8'hCA, 1'b0);
    rdChk(CTRL, 8'h60, "low flag only");
    chk({7'h0, timerIrq}, 8'h01, "low wrap irq");
    irqEn = 1'b0;
    tick(2);
    chk({7'h0, timerIrq}, 8'h00, "controller enable off");
    irqEn = 1'b1;
    bw(8'hCD, 1'b0);
    tick(1);
    chk({7'h0, timerIrq}, 8'h00, "low enable off");
    tick(30);
    rdChk(CTRL, 8'h40, "flag sticks");
    // Split mode: low runs regardless of run bit
    wr(CTRL, 8'h00);
    highFast = 1'b1;
    wr(CNTL, 8'hFE);
    wr(CNTH, 8'hFE);
    wr(CTRL, 8'h08);
    tick(6);
    rdChk(CNTH, 8'hFE, "high gated by run");
    rdChk(CTRL, 8'h48, "split low flag");
    chk({7'h0, timerIrq}, 8'h00, "low flag masked");
    bw(8'hCD, 1'b1);
    chk({7'h0, timerIrq}, 8'h01, "low flag unmasked");
    bw(8'hCA, 1'b1);
    tick(4);
    rdChk(CTRL, 8'hEC, "split high flag");
    rd(CNTL, rdVal);
    chk(inRange(8'(rdVal - rl), 1, 40), 8'h01, "low reloaded");
    // Divided clock sources on the low byte
    highFast = 1'b0;
    lowFast = 1'b0;
    wr(CTRL, 8'h08);
    wr(CNTL, 8'h00);
    tick(120);
    rd(CNTL, rdVal);
    chk(inRange(rdVal, 9, 12), 8'h01, "system clock over twelve");
    // High byte on the divided system clock with run set, then the low byte on external /8 with run clear
    wr(CTRL, 8'h0C);
    wr(CNTH, 8'h00);
    tick(120);
    rd(CNTH, rdVal);
    chk(inRange(rdVal, 9, 12), 8'h01, "high byte over twelve");
    wr(CTRL, 8'h09);
    wr(CNTL, 8'h00);
    repeat (16) begin
      extClk = 1'b1;
      tick(2);
      extClk = 1'b0;
      tick(2);
    end
    tick(8);
    rdChk(CNTL, 8'h02, "external over eight");
    end_of_test();
  end
endmodule : tb

`default_nettype wire
